/* ppp_regs.svh */
// Constants for the parallel programming port: command codes, action codes, geometry, timing.
// Assumes a 100 MHz clock on both ends.
`ifndef PPP_REGS_SVH
`define PPP_REGS_SVH

`define CMD_NOP          8'h00
`define CMD_CHIP_ERASE   8'h80
`define CMD_WRITE_FLASH  8'h10
`define CMD_WRITE_EEPROM 8'h11
`define CMD_READ_FLASH   8'h02
`define CMD_READ_EEPROM  8'h03

`define ACT_ADDR         2'h0
`define ACT_DATA         2'h1
`define ACT_CMD          2'h2
`define ACT_IDLE         2'h3

`define FLASH_PAGE_BITS  5
`define FLASH_ADDR_BITS  6
`define EE_PAGE_BITS     2
`define EE_ADDR_BITS     6
`define ERASED_BYTE      8'hFF

`define CLK_PERIOD_NS    10
`define ENTRY_HOLD_NS    10000
`define ENTRY_HOLD_CYC   ((`ENTRY_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ENTRY_WAIT_NS    300000
`define ENTRY_WAIT_CYC   ((`ENTRY_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PROG_BUSY_CYC    16
`define PULSE_CYC        4

`endif

/* ppp_pkg.sv */
// Types shared by both ends of the parallel programming port.
// Assumes ppp_regs.svh for the widths.
`include "ppp_regs.svh"

package ppp_pkg;

    typedef enum logic [2:0]
    {
        DEV_OFF    = 3'h0,
        DEV_READY  = 3'h1,
        DEV_ERASE  = 3'h3,
        DEV_WRITE  = 3'h5
    } dev_state_type;

    typedef enum logic [3:0]
    {
        PRG_IDLE   = 4'h0,
        PRG_ENTRY  = 4'h1,
        PRG_WAIT   = 4'h3,
        PRG_SETUP  = 4'h2,
        PRG_STROBE = 4'h6,
        PRG_RELAX  = 4'h7,
        PRG_BUSY   = 4'h5,
        PRG_READ   = 4'h4,
        PRG_DONE   = 4'hC
    } prg_state_type;

    typedef enum logic [2:0]
    {
        OP_LOAD   = 3'h0,
        OP_LATCH  = 3'h1,
        OP_WRITE  = 3'h2,
        OP_READ   = 3'h3,
        OP_EXIT   = 3'h4
    } op_type;

endpackage

/* ppp_if.sv */
// Pin bundle between the device's programming port and the external programmer.
// Assumes the testbench resolves the data bus from the two output enables.
`timescale 1ns/1ps

interface ppp_if;
    logic       hv_reset;
    logic       action_select_hi;
    logic       action_select_lo;
    logic       byte_select_upper;
    logic       page_latch_strobe;
    logic       load_strobe;
    logic       write_n;
    logic       output_enable_n;
    logic       ready_busy_n;
    logic [7:0] data_from_prog;
    logic       data_prog_oe_n;
    logic [7:0] data_from_dev;
    logic       data_dev_oe_n;
    logic [7:0] data_to_dev;
    logic [7:0] data_to_prog;

    modport device
    (
        input  hv_reset, action_select_hi, action_select_lo, byte_select_upper,
        input  page_latch_strobe, load_strobe, write_n, output_enable_n, data_to_dev,
        output ready_busy_n, data_from_dev, data_dev_oe_n
    );

    modport programmer
    (
        input  ready_busy_n, data_to_prog,
        output hv_reset, action_select_hi, action_select_lo, byte_select_upper,
        output page_latch_strobe, load_strobe, write_n, output_enable_n,
        output data_from_prog, data_prog_oe_n
    );
endinterface

/* ppp_device.sv */
// Device end of the parallel programming port: command/address/data loading, page buffers,
// chip erase, flash and EEPROM page writes and reads. Memories are flip-flop arrays.
// Assumes all pin inputs are asynchronous and are synchronised here.
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "ppp_regs.svh"

module ppp_device
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // Programming pins
    ppp_if.device           pins,
    // Straps and status
    input  wire logic       eeprom_preserve_fuse,
    output logic            in_prog_mode,
    output logic [1:0]      lock_bits
);

    localparam int FW = 1 << `FLASH_ADDR_BITS + `FLASH_PAGE_BITS;
    localparam int EW = 1 << `EE_ADDR_BITS + `EE_PAGE_BITS;
    localparam int FP = 1 << `FLASH_PAGE_BITS;
    localparam int EP = 1 << `EE_PAGE_BITS;

    // ********************************
    // Input synchronisers
    // ********************************
    localparam int NS = 16;
    logic [NS-1:0] sync1;
    logic [NS-1:0] sync2;
    logic [NS-1:0] raw;
    assign raw = {pins.hv_reset, pins.action_select_hi, pins.action_select_lo, pins.byte_select_upper,
                  pins.page_latch_strobe, pins.load_strobe, pins.write_n, pins.output_enable_n,
                  pins.data_to_dev};
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sync1 <= '0;
            sync2 <= '0;
        end
        else
        begin
            sync1 <= raw;
            sync2 <= sync1;
        end
    end
    logic       s_hv;
    logic [1:0] s_act;
    logic       s_bs;
    logic       s_pl;
    logic       s_ld;
    logic       s_wr_n;
    logic       s_oe_n;
    logic [7:0] s_data;
    assign {s_hv, s_act, s_bs, s_pl, s_ld, s_wr_n, s_oe_n, s_data} = sync2;

    // ********************************
    // State
    // ********************************
    typedef struct packed
    {
        ppp_pkg::dev_state_type state;
        logic                   ld_q;
        logic                   pl_q;
        logic                   wr_q;
        logic [7:0]             cmd;
        logic [7:0]             addr_lo;
        logic [7:0]             addr_hi;
        logic [7:0]             data_lo;
        logic [7:0]             data_hi;
        logic [15:0]            count;
        logic [FP-1:0]          fbuf_valid;
        logic [EP-1:0]          ebuf_valid;
        logic [1:0]             lock;
        logic                   flash_done;
        logic [7:0]             dout;
    } dev_type;

    dev_type r;
    dev_type next_r;
    logic [15:0] flash_mem [FW];
    logic [15:0] fbuf [FP];
    logic [7:0]  ee_mem [EW];
    logic [7:0]  ebuf [EP];

    logic [`FLASH_ADDR_BITS+`FLASH_PAGE_BITS-1:0] faddr;
    logic [`EE_ADDR_BITS+`EE_PAGE_BITS-1:0]       eaddr;
    assign faddr = {r.addr_hi[`FLASH_ADDR_BITS-4:0], r.addr_lo};
    // EEPROM fits in one 256-byte window, so only the low address byte counts
    assign eaddr = r.addr_lo;

    logic ld_rise;
    logic pl_rise;
    logic wr_fall;
    assign ld_rise = s_ld && !r.ld_q;
    assign pl_rise = s_pl && !r.pl_q;
    assign wr_fall = !s_wr_n && r.wr_q;

    always_comb
    begin
        next_r = r;
        next_r.ld_q = s_ld;
        next_r.pl_q = s_pl;
        next_r.wr_q = s_wr_n;
        unique case (r.state)
            ppp_pkg::DEV_OFF:
            begin
                if (s_hv)
                    next_r.state = ppp_pkg::DEV_READY;
            end
            ppp_pkg::DEV_READY:
            begin
                if (ld_rise && s_act == `ACT_CMD)
                begin
                    next_r.cmd = s_data;
                    if (s_data == `CMD_NOP)
                    begin
                        next_r.fbuf_valid = '0;
                        next_r.ebuf_valid = '0;
                    end
                end
                else if (ld_rise && s_act == `ACT_ADDR)
                begin
                    if (s_bs)
                        next_r.addr_hi = s_data;
                    else
                        next_r.addr_lo = s_data;
                end
                else if (ld_rise && s_act == `ACT_DATA)
                begin
                    if (s_bs)
                        next_r.data_hi = s_data;
                    else
                        next_r.data_lo = s_data;
                end
                if (pl_rise && r.cmd == `CMD_WRITE_FLASH)
                    next_r.fbuf_valid[r.addr_lo[`FLASH_PAGE_BITS-1:0]] = 1'b1;
                if (pl_rise && r.cmd == `CMD_WRITE_EEPROM)
                    next_r.ebuf_valid[r.addr_lo[`EE_PAGE_BITS-1:0]] = 1'b1;
                if (wr_fall && (r.cmd == `CMD_WRITE_FLASH || r.cmd == `CMD_WRITE_EEPROM))
                begin
                    next_r.state = ppp_pkg::DEV_WRITE;
                    next_r.count = 16'(`PROG_BUSY_CYC);
                end
                if (wr_fall && r.cmd == `CMD_CHIP_ERASE)
                begin
                    next_r.state = ppp_pkg::DEV_ERASE;
                    next_r.count = 16'(`PROG_BUSY_CYC);
                    next_r.flash_done = 1'b0;
                end
            end
            ppp_pkg::DEV_WRITE:
            begin
                next_r.count = r.count - 16'h0001;
                if (r.count == 16'h0001)
                begin
                    next_r.state = ppp_pkg::DEV_READY;
                    next_r.fbuf_valid = '0;
                    next_r.ebuf_valid = '0;
                end
            end
            ppp_pkg::DEV_ERASE:
            begin
                next_r.count = r.count - 16'h0001;
                if (r.count == 16'h0002)
                    next_r.flash_done = 1'b1;
                if (r.count == 16'h0001)
                begin
                    if (r.flash_done)
                        next_r.lock = 2'h3;
                    next_r.state = ppp_pkg::DEV_READY;
                end
            end
            default:
                next_r.state = ppp_pkg::DEV_OFF;
        endcase
        if (r.cmd == `CMD_READ_FLASH)
            next_r.dout = s_bs ? flash_mem[faddr][15:8] : flash_mem[faddr][7:0];
        else if (r.cmd == `CMD_READ_EEPROM && !s_bs)
            next_r.dout = ee_mem[eaddr];
        else
            next_r.dout = `ERASED_BYTE;
        if (!s_hv)
        begin
            next_r = '0;
            next_r.state = ppp_pkg::DEV_OFF;
            next_r.lock = r.lock;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            r <= '0;
            r.lock <= 2'h3;
        end
        else
            r <= next_r;
    end

    // ********************************
    // Page buffers and arrays
    // ********************************
    always_ff @(posedge clk)
    begin
        if (r.state == ppp_pkg::DEV_READY && pl_rise)
        begin
            fbuf[r.addr_lo[`FLASH_PAGE_BITS-1:0]] <= {r.data_hi, r.data_lo};
            ebuf[r.addr_lo[`EE_PAGE_BITS-1:0]] <= r.data_lo;
        end
        for (int i = 0; i < FW; i++)
        begin
            if (r.state == ppp_pkg::DEV_ERASE && r.count == 16'h0002)
                flash_mem[i] <= {2{`ERASED_BYTE}};
            else if (r.state == ppp_pkg::DEV_WRITE && r.count == 16'h0001 && r.cmd == `CMD_WRITE_FLASH
                     && i[`FLASH_ADDR_BITS+`FLASH_PAGE_BITS-1:`FLASH_PAGE_BITS]
                        == faddr[`FLASH_ADDR_BITS+`FLASH_PAGE_BITS-1:`FLASH_PAGE_BITS]
                     && r.fbuf_valid[i[`FLASH_PAGE_BITS-1:0]])
                flash_mem[i] <= fbuf[i[`FLASH_PAGE_BITS-1:0]];
        end
        for (int j = 0; j < EW; j++)
        begin
            if (r.state == ppp_pkg::DEV_ERASE && r.count == 16'h0002 && !eeprom_preserve_fuse)
                ee_mem[j] <= `ERASED_BYTE;
            else if (r.state == ppp_pkg::DEV_WRITE && r.count == 16'h0001 && r.cmd == `CMD_WRITE_EEPROM
                     && j[`EE_ADDR_BITS+`EE_PAGE_BITS-1:`EE_PAGE_BITS]
                        == eaddr[`EE_ADDR_BITS+`EE_PAGE_BITS-1:`EE_PAGE_BITS]
                     && r.ebuf_valid[j[`EE_PAGE_BITS-1:0]])
                ee_mem[j] <= ebuf[j[`EE_PAGE_BITS-1:0]];
        end
    end

    // ********************************
    // Outputs
    // ********************************
    assign pins.ready_busy_n = (r.state == ppp_pkg::DEV_READY);
    assign pins.data_from_dev = r.dout;
    assign pins.data_dev_oe_n = !(r.state != ppp_pkg::DEV_OFF && !s_oe_n);
    assign in_prog_mode = (r.state != ppp_pkg::DEV_OFF);
    assign lock_bits = r.lock;

endmodule

/* ppp_programmer.sv */
// Programmer end: enters programming mode and runs load, latch, write, read and exit operations.
// Assumes user ops are requested with op_valid and accepted while op_ready is high.
`timescale 1ns/1ps
`include "ppp_regs.svh"

module ppp_programmer
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // Pins
    ppp_if.programmer       pins,
    // User side
    input  wire logic       op_valid,
    output logic            op_ready,
    input  ppp_pkg::op_type op_code,
    input  wire logic [1:0] op_action,
    input  wire logic       op_byte_upper,
    input  wire logic [7:0] op_data,
    output logic [7:0]      rd_data,
    output logic            rd_valid
);

    typedef struct packed
    {
        ppp_pkg::prg_state_type state;
        ppp_pkg::op_type        op;
        logic [15:0]            count;
        logic                   hv;
        logic [1:0]             act;
        logic                   bs;
        logic                   pl;
        logic                   ld;
        logic                   wr_n;
        logic                   oe_n;
        logic [7:0]             dout;
        logic                   drive;
        logic [7:0]             rd;
        logic                   rdv;
        logic                   rb_q1;
        logic                   rb_q2;
    } prg_type;

    prg_type r;
    prg_type next_r;

    always_comb
    begin
        next_r = r;
        next_r.rdv = 1'b0;
        next_r.rb_q1 = pins.ready_busy_n;
        next_r.rb_q2 = r.rb_q1;
        if (r.count != 16'h0000)
            next_r.count = r.count - 16'h0001;
        unique case (r.state)
            ppp_pkg::PRG_IDLE:
            begin
                next_r.hv = 1'b1;
                next_r.act = 2'h0;
                next_r.bs = 1'b0;
                next_r.pl = 1'b0;
                next_r.count = 16'(`ENTRY_HOLD_CYC);
                next_r.state = ppp_pkg::PRG_ENTRY;
            end
            ppp_pkg::PRG_ENTRY:
            begin
                if (r.count == 16'h0000)
                begin
                    next_r.act = `ACT_IDLE;
                    next_r.count = 16'(`ENTRY_WAIT_CYC);
                    next_r.state = ppp_pkg::PRG_WAIT;
                end
            end
            ppp_pkg::PRG_WAIT:
            begin
                if (r.count == 16'h0000)
                    next_r.state = ppp_pkg::PRG_SETUP;
            end
            ppp_pkg::PRG_SETUP:
            begin
                if (op_valid)
                begin
                    next_r.op = op_code;
                    next_r.act = op_action;
                    next_r.bs = op_byte_upper;
                    next_r.dout = op_data;
                    next_r.drive = (op_code == ppp_pkg::OP_LOAD);
                    next_r.count = 16'(`PULSE_CYC);
                    next_r.state = ppp_pkg::PRG_STROBE;
                    if (op_code == ppp_pkg::OP_EXIT)
                    begin
                        next_r.hv = 1'b0;
                        next_r.state = ppp_pkg::PRG_DONE;
                    end
                end
            end
            ppp_pkg::PRG_STROBE:
            begin
                next_r.ld = (r.op == ppp_pkg::OP_LOAD);
                next_r.pl = (r.op == ppp_pkg::OP_LATCH);
                next_r.wr_n = (r.op != ppp_pkg::OP_WRITE);
                next_r.oe_n = (r.op != ppp_pkg::OP_READ);
                if (r.count == 16'h0000)
                begin
                    next_r.count = 16'(`PULSE_CYC);
                    next_r.state = (r.op == ppp_pkg::OP_READ) ? ppp_pkg::PRG_READ : ppp_pkg::PRG_RELAX;
                end
            end
            ppp_pkg::PRG_READ:
            begin
                if (r.count == 16'h0000)
                begin
                    next_r.rd = pins.data_to_prog;
                    next_r.rdv = 1'b1;
                    next_r.oe_n = 1'b1;
                    next_r.count = 16'(`PULSE_CYC);
                    next_r.state = ppp_pkg::PRG_RELAX;
                end
            end
            ppp_pkg::PRG_RELAX:
            begin
                next_r.ld = 1'b0;
                next_r.pl = 1'b0;
                next_r.wr_n = 1'b1;
                if (r.count == 16'h0000)
                begin
                    next_r.drive = 1'b0;
                    next_r.count = 16'(`PULSE_CYC);
                    next_r.state = (r.op == ppp_pkg::OP_WRITE) ? ppp_pkg::PRG_BUSY : ppp_pkg::PRG_SETUP;
                end
            end
            ppp_pkg::PRG_BUSY:
            begin
                if (r.count == 16'h0000 && r.rb_q2)
                    next_r.state = ppp_pkg::PRG_SETUP;
            end
            ppp_pkg::PRG_DONE:
            begin
                next_r.hv = 1'b0;
            end
            default:
                next_r.state = ppp_pkg::PRG_DONE;
        endcase
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            r <= '0;
            r.wr_n <= 1'b1;
            r.oe_n <= 1'b1;
        end
        else
            r <= next_r;
    end

    assign op_ready = (r.state == ppp_pkg::PRG_SETUP);
    assign pins.hv_reset = r.hv;
    assign pins.action_select_hi = r.act[1];
    assign pins.action_select_lo = r.act[0];
    assign pins.byte_select_upper = r.bs;
    assign pins.page_latch_strobe = r.pl;
    assign pins.load_strobe = r.ld;
    assign pins.write_n = r.wr_n;
    assign pins.output_enable_n = r.oe_n;
    assign pins.data_from_prog = r.dout;
    assign pins.data_prog_oe_n = !r.drive;
    assign rd_data = r.rd;
    assign rd_valid = r.rdv;

endmodule

/* ppp_pins_properties.sv */
// Assertions on the pins joining programmer and device.
// Assumes the testbench wires it to the interface signals.
`timescale 1ns/1ps
`include "ppp_regs.svh"
module ppp_pins_properties
(
    // Clock and reset
    input wire logic       clk,
    input wire logic       resetn,
    // Pins
    input wire logic       hv_reset,
    input wire logic       action_select_hi,
    input wire logic       action_select_lo,
    input wire logic       byte_select_upper,
    input wire logic       page_latch_strobe,
    input wire logic       load_strobe,
    input wire logic       write_n,
    input wire logic       output_enable_n,
    input wire logic       ready_busy_n,
    input wire logic [7:0] data_from_prog,
    input wire logic       data_prog_oe_n,
    input wire logic       data_dev_oe_n
);
    // **********
    // Helper counters
    // **********
    logic [15:0] hv_cnt;
    logic [3:0]  oe_hi;
    logic [7:0]  bsy;
    logic        rb_q;
    logic        in_bsy;
    logic        next_in_bsy;

    // Busy period counted only when it starts from ready inside programming mode
    assign next_in_bsy = hv_reset && !ready_busy_n && (in_bsy || rb_q);

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            hv_cnt <= 16'h0;
            oe_hi  <= 4'hF;
            bsy    <= 8'h00;
            rb_q   <= 1'b0;
            in_bsy <= 1'b0;
        end
        else
        begin
            hv_cnt <= !hv_reset ? 16'h0 : hv_cnt + {15'h0, hv_cnt != 16'hFFFF};
            oe_hi  <= output_enable_n ? oe_hi + {3'h0, oe_hi != 4'hF} : 4'h0;
            bsy    <= next_in_bsy ? bsy + 8'h01 : 8'h00;
            rb_q   <= ready_busy_n;
            in_bsy <= next_in_bsy;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    entry_pins_held_a: assert property (hv_reset && hv_cnt < `ENTRY_HOLD_CYC
        |-> !{page_latch_strobe, action_select_hi, action_select_lo, byte_select_upper})
        else $error("entry pins moved during hold");
    entry_wait_a: assert property (hv_cnt < `ENTRY_HOLD_CYC + `ENTRY_WAIT_CYC
        |-> !load_strobe && !page_latch_strobe && write_n) else $error("strobe before entry wait");
    one_bus_driver_a: assert property (data_dev_oe_n || data_prog_oe_n)
        else $error("both ends drive data");
    drive_on_oe_a: assert property (!data_dev_oe_n |-> oe_hi < 4'h6)
        else $error("device drives without output enable");
    exit_release_a: assert property ($fell(hv_reset) |-> ##[1:6] (data_dev_oe_n && !ready_busy_n))
        else $error("device stays in programming mode");
    write_busy_a: assert property ($fell(write_n) && hv_reset |-> ##[1:8] !ready_busy_n)
        else $error("write pulse did not raise busy");
    busy_span_a: assert property ($rose(ready_busy_n) && in_bsy
        |-> bsy >= `PROG_BUSY_CYC && bsy <= `PROG_BUSY_CYC + 2) else $error("busy span wrong");
    load_pulse_a: assert property ($rose(load_strobe) |-> load_strobe[*5] ##1 !load_strobe)
        else $error("load pulse shape wrong");
    load_stable_a: assert property (load_strobe && $past(load_strobe) |-> $stable(data_from_prog)
        && $stable({action_select_hi, action_select_lo, byte_select_upper}) && !data_prog_oe_n)
        else $error("load fields moved in pulse");
    strobe_ready_a: assert property ($rose(load_strobe) || $rose(page_latch_strobe) |-> ready_busy_n)
        else $error("strobe while busy");
endmodule

/* parallel_program_port_tb.sv */
// Testbench: programmer and device joined by the pin interface.
// Assumes the design files and the pin checker are compiled first.
`timescale 1ns/1ps
`include "ppp_regs.svh"
module parallel_program_port_tb;
    logic            clk = 1'b0;
    logic            resetn = 1'b0;
    logic            op_valid = 1'b0;
    logic            op_ready;
    ppp_pkg::op_type op_code = ppp_pkg::OP_LOAD;
    logic [1:0]      op_action = `ACT_IDLE;
    logic            op_byte_upper = 1'b0;
    logic [7:0]      op_data = 8'h00;
    logic [7:0]      rd_data;
    logic            rd_valid;
    logic            eeprom_preserve_fuse = 1'b0;
    logic            in_prog_mode;
    logic [1:0]      lock_bits;
    logic [7:0]      float_pat = 8'h5A;
    int              failures = 0;
    int              compares = 0;

    ppp_if pins();
    always #5 clk = ~clk;
    // Undriven bus shows a changing pattern
    always @(posedge clk) float_pat <= float_pat + 8'h3B;
    wire logic [7:0] bus = !pins.data_prog_oe_n ? pins.data_from_prog
                         : !pins.data_dev_oe_n ? pins.data_from_dev : float_pat;
    assign pins.data_to_dev  = bus;
    assign pins.data_to_prog = bus;

    ppp_device u_ppp_device
    (
        .clk(clk), .resetn(resetn), .pins(pins.device), .eeprom_preserve_fuse(eeprom_preserve_fuse),
        .in_prog_mode(in_prog_mode), .lock_bits(lock_bits)
    );
    ppp_programmer u_ppp_programmer
    (
        .clk(clk), .resetn(resetn), .pins(pins.programmer), .op_valid(op_valid), .op_ready(op_ready),
        .op_code(op_code), .op_action(op_action), .op_byte_upper(op_byte_upper), .op_data(op_data),
        .rd_data(rd_data), .rd_valid(rd_valid)
    );
    ppp_pins_properties u_pins_check
    (
        .clk(clk), .resetn(resetn), .hv_reset(pins.hv_reset), .action_select_hi(pins.action_select_hi),
        .action_select_lo(pins.action_select_lo), .byte_select_upper(pins.byte_select_upper),
        .page_latch_strobe(pins.page_latch_strobe), .load_strobe(pins.load_strobe), .write_n(pins.write_n),
        .output_enable_n(pins.output_enable_n), .ready_busy_n(pins.ready_busy_n),
        .data_from_prog(pins.data_from_prog), .data_prog_oe_n(pins.data_prog_oe_n),
        .data_dev_oe_n(pins.data_dev_oe_n)
    );

    // **********
    // Tasks
    // **********
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic op(input ppp_pkg::op_type c, input logic [1:0] a, input logic u, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        op_valid      <= 1'b1;
        op_code       <= c;
        op_action     <= a;
        op_byte_upper <= u;
        op_data       <= d;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (op_ready !== 1'b1 && n < 40000);
        @(posedge clk);
        op_valid <= 1'b0;
        if (n >= 40000)
            check(8'h00, 8'h01);
    endtask

    task automatic ld(input logic [1:0] a, input logic u, input logic [7:0] d);
        op(ppp_pkg::OP_LOAD, a, u, d);
    endtask

    task automatic rd(input logic u, input logic [7:0] e);
        int n;
        n = 0;
        op(ppp_pkg::OP_READ, `ACT_IDLE, u, 8'h00);
        do
        begin
            @(negedge clk);
            n++;
        end
        while (rd_valid !== 1'b1 && n < 100);
        if (n >= 100)
            check(8'h00, 8'h01);
        check(rd_data, e);
    endtask

    task automatic erase(input logic keep);
        eeprom_preserve_fuse <= keep;
        ld(`ACT_CMD, 1'b0, `CMD_CHIP_ERASE);
        op(ppp_pkg::OP_WRITE, `ACT_IDLE, 1'b0, 8'h00);
    endtask

    task automatic t_flash;
        erase(1'b0);
        check({6'h00, lock_bits}, 8'h03);
        ld(`ACT_CMD, 1'b0, `CMD_WRITE_FLASH);
        ld(`ACT_ADDR, 1'b0, 8'h21);
        ld(`ACT_DATA, 1'b0, 8'h5C);
        ld(`ACT_DATA, 1'b1, 8'hA3);
        op(ppp_pkg::OP_LATCH, `ACT_IDLE, 1'b1, 8'h00);
        ld(`ACT_ADDR, 1'b1, 8'h01);
        op(ppp_pkg::OP_WRITE, `ACT_IDLE, 1'b0, 8'h00);
        ld(`ACT_CMD, 1'b0, `CMD_NOP);
        ld(`ACT_CMD, 1'b0, `CMD_READ_FLASH);
        ld(`ACT_IDLE, 1'b0, 8'h01);
        rd(1'b0, 8'h5C);
        rd(1'b1, 8'hA3);
        ld(`ACT_ADDR, 1'b0, 8'h01);
        rd(1'b0, 8'hFF);
        // Latched word must be dropped by the no-operation command
        ld(`ACT_CMD, 1'b0, `CMD_WRITE_FLASH);
        ld(`ACT_DATA, 1'b0, 8'h77);
        op(ppp_pkg::OP_LATCH, `ACT_IDLE, 1'b1, 8'h00);
        ld(`ACT_CMD, 1'b0, `CMD_NOP);
        ld(`ACT_CMD, 1'b0, `CMD_WRITE_FLASH);
        op(ppp_pkg::OP_WRITE, `ACT_IDLE, 1'b0, 8'h00);
        ld(`ACT_CMD, 1'b0, `CMD_READ_FLASH);
        rd(1'b0, 8'hFF);
        $display("flash test done");
    endtask

    task automatic t_eeprom;
        ld(`ACT_CMD, 1'b0, `CMD_WRITE_EEPROM);
        ld(`ACT_ADDR, 1'b1, 8'h00);
        for (int i = 0; i < 2; i++)
        begin
            ld(`ACT_ADDR, 1'b0, 8'h06 + 8'(i));
            ld(`ACT_DATA, 1'b0, i ? 8'hC3 : 8'h3C);
            op(ppp_pkg::OP_LATCH, `ACT_IDLE, 1'b0, 8'h00);
        end
        op(ppp_pkg::OP_WRITE, `ACT_IDLE, 1'b0, 8'h00);
        ld(`ACT_CMD, 1'b0, `CMD_READ_EEPROM);
        ld(`ACT_ADDR, 1'b0, 8'h06);
        rd(1'b0, 8'h3C);
        ld(`ACT_ADDR, 1'b0, 8'h07);
        rd(1'b0, 8'hC3);
        erase(1'b1);
        ld(`ACT_CMD, 1'b0, `CMD_READ_EEPROM);
        rd(1'b0, 8'hC3);
        erase(1'b0);
        ld(`ACT_CMD, 1'b0, `CMD_READ_EEPROM);
        rd(1'b0, 8'hFF);
        ld(`ACT_CMD, 1'b0, `CMD_READ_FLASH);
        ld(`ACT_ADDR, 1'b1, 8'h01);
        ld(`ACT_ADDR, 1'b0, 8'h21);
        rd(1'b1, 8'hFF);
        $display("eeprom test done");
    endtask

    task automatic t_exit;
        int n;
        n = 0;
        op(ppp_pkg::OP_EXIT, `ACT_IDLE, 1'b0, 8'h00);
        while (in_prog_mode !== 1'b0 && n < 100)
        begin
            @(posedge clk);
            n++;
        end
        check({7'h00, in_prog_mode}, 8'h00);
        $display("exit test done");
    endtask

    task automatic summarize;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        repeat (16) @(posedge clk);
        check({7'h00, pins.ready_busy_n}, 8'h00);
        check({7'h00, pins.data_dev_oe_n}, 8'h01);
        $display("reset test done");
        resetn <= 1'b1;
        t_flash();
        t_eeprom();
        t_exit();
        summarize();
    end

    initial
    begin
        repeat (60000) @(posedge clk);
        failures++;
        summarize();
    end
endmodule
